// >>> cops_pkg.sv
// Constants and types shared by the clock output postscaler.
// Assumes a single 125 MHz system clock standing in for the multiplied reference.
package cops_pkg;

  // ==========================================================================
  // Clock plan
  // ==========================================================================
  localparam int unsigned COPS_REF_MHZ     = 25;
  localparam int unsigned COPS_PLL_MULT    = 4;
  localparam int unsigned COPS_BASE_MHZ    = COPS_REF_MHZ * COPS_PLL_MULT;
  localparam int unsigned COPS_SYS_MHZ     = 125;
  localparam int unsigned COPS_ACC_W       = 8;

  // ==========================================================================
  // Control word layout
  // ==========================================================================
  localparam int unsigned COPS_CTRL_W      = 16;
  localparam int unsigned COPS_CFG_LSB     = 8;
  localparam int unsigned COPS_CFG_MSB     = 11;
  localparam int unsigned COPS_CFG_W       = COPS_CFG_MSB - COPS_CFG_LSB + 1;

  // ==========================================================================
  // Configuration codes and divide ratios
  // ==========================================================================
  localparam logic [3:0]  COPS_CODE_OFF    = 4'h0;
  localparam logic [3:0]  COPS_CODE_RESET  = 4'h7;
  localparam int unsigned COPS_DIV_W       = 10;
  localparam logic [9:0]  COPS_DIV_MIN     = 10'h004;

  typedef logic [COPS_DIV_W-1:0] cops_div_t;

  // Divide ratio of the base clock for each code; code 0 holds the pin low
  function automatic cops_div_t cops_div_of(input logic [3:0] code);
    case (code)
      4'h1:    cops_div_of = 10'h004;
      4'h2:    cops_div_of = 10'h005;
      4'h3:    cops_div_of = 10'h008;
      4'h4:    cops_div_of = 10'h00A;
      4'h5:    cops_div_of = 10'h010;
      4'h6:    cops_div_of = 10'h014;
      4'h7:    cops_div_of = 10'h019;
      4'h8:    cops_div_of = 10'h020;
      4'h9:    cops_div_of = 10'h028;
      4'hA:    cops_div_of = 10'h032;
      4'hB:    cops_div_of = 10'h040;
      4'hC:    cops_div_of = 10'h064;
      4'hD:    cops_div_of = 10'h0C8;
      4'hE:    cops_div_of = 10'h190;
      4'hF:    cops_div_of = 10'h3E8;
      default: cops_div_of = 10'h000;
    endcase
  endfunction

  typedef struct packed {
    logic                   wr;
    logic [COPS_CTRL_W-1:0] data;
  } cops_ctrl_wr_t;

  typedef enum logic [1:0] {
    COPS_ST_OFF  = 2'b00,
    COPS_ST_HIGH = 2'b01,
    COPS_ST_LOW  = 2'b10
  } cops_state_t;

endpackage

// >>> cops_base_tick.sv
// Base clock tick generator: a one-cycle enable at the 100 MHz base rate.
// Assumes clk_sys runs at the rate named in the package.
`timescale 1ns/1ps

module cops_base_tick
  import cops_pkg::*;
#(
  parameter int unsigned SYS_MHZ  = COPS_SYS_MHZ,
  parameter int unsigned BASE_MHZ = COPS_BASE_MHZ
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      base_tick
);

  initial begin
    if (BASE_MHZ > SYS_MHZ || SYS_MHZ >= (1 << (COPS_ACC_W - 1)))
      $error("cops_base_tick: base rate must not exceed system rate");
  end

  localparam logic [COPS_ACC_W-1:0] STEP = COPS_ACC_W'(BASE_MHZ);
  localparam logic [COPS_ACC_W-1:0] WRAP = COPS_ACC_W'(SYS_MHZ);

  logic [COPS_ACC_W-1:0] acc_reg;
  logic [COPS_ACC_W-1:0] acc_sum;

  // ==========================================================================
  // Fractional accumulator: reference times four, spread over system cycles
  // ==========================================================================
  assign acc_sum = acc_reg + STEP;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg   <= '0;
      base_tick <= 1'b0;
    end else if (acc_sum >= WRAP) begin
      acc_reg   <= acc_sum - WRAP;
      base_tick <= 1'b1;
    end else begin
      acc_reg   <= acc_sum;
      base_tick <= 1'b0;
    end
  end

endmodule

// >>> cops_top.sv
// Clock output postscaler: divides the base clock to drive the clock output pin.
// Assumes rst_n is the power-on reset only; other resets and power-down stay outside.
`timescale 1ns/1ps

module cops_top
  import cops_pkg::*;
#(
  parameter logic [3:0] RESET_CODE = COPS_CODE_RESET
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire cops_ctrl_wr_t ctrl_wr,
  input  wire logic          sys_reset_req,
  input  wire logic          power_down,
  output logic               clock_output_pin,
  output logic [3:0]         clock_output_config,
  output logic               change_pending,
  output logic               link_domain_reset
);

  initial begin
    if (cops_div_of(RESET_CODE) < COPS_DIV_MIN)
      $error("cops_top: reset code must select a running divisor");
    // Each half period needs at least two base periods for the phase counters
    for (int code = 1; code < 16; code++) begin
      if (cops_div_of(4'(code)) < COPS_DIV_MIN)
        $error("cops_top: every running code must select at least the minimum divisor");
    end
  end

  // ==========================================================================
  // Base clock enable
  // ==========================================================================
  logic base_tick;

  cops_base_tick u_base_tick (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .base_tick (base_tick)
  );

  // ==========================================================================
  // Configuration field
  // ==========================================================================
  logic [3:0]  cfg_reg;
  logic [3:0]  active_code_reg;
  logic        pending_reg;
  cops_div_t   active_div;
  cops_div_t   high_len;
  cops_div_t   low_len;
  cops_div_t   phase_cnt_reg;
  cops_state_t state_reg;
  logic        period_end;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= RESET_CODE;
    end else if (ctrl_wr.wr) begin
      cfg_reg <= ctrl_wr.data[COPS_CFG_MSB:COPS_CFG_LSB];
    end
  end

  assign clock_output_config = cfg_reg;

  // A new write wins over the boundary that would clear the pending flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (ctrl_wr.wr) begin
      pending_reg <= 1'b1;
    end else if (period_end) begin
      pending_reg <= 1'b0;
    end
  end

  assign change_pending = pending_reg;

  // ==========================================================================
  // Postscaler
  // ==========================================================================
  assign active_div = cops_div_of(active_code_reg);
  assign low_len    = active_div >> 1;
  assign high_len   = active_div - low_len;

  // Boundary: end of a low phase, or any tick while stopped
  assign period_end = base_tick &&
                      ((state_reg == COPS_ST_OFF) ||
                       (state_reg == COPS_ST_LOW && phase_cnt_reg == low_len - 10'h001));

  // Active code is loaded only at a boundary
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_code_reg <= RESET_CODE;
    end else if (period_end) begin
      active_code_reg <= cfg_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= COPS_ST_OFF;
      phase_cnt_reg <= '0;
    end else if (base_tick) begin
      case (state_reg)
        COPS_ST_OFF: begin
          phase_cnt_reg <= '0;
          if (cops_div_of(cfg_reg) != 10'h000) begin
            state_reg <= COPS_ST_HIGH;
          end
        end
        COPS_ST_HIGH: begin
          if (phase_cnt_reg == high_len - 10'h001) begin
            phase_cnt_reg <= '0;
            state_reg     <= COPS_ST_LOW;
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 10'h001;
          end
        end
        COPS_ST_LOW: begin
          if (period_end) begin
            phase_cnt_reg <= '0;
            state_reg     <= (cops_div_of(cfg_reg) != 10'h000) ? COPS_ST_HIGH : COPS_ST_OFF;
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 10'h001;
          end
        end
        default: begin
          phase_cnt_reg <= '0;
          state_reg     <= COPS_ST_OFF;
        end
      endcase
    end
  end

  // Output from a flop: high only in the high phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin <= 1'b0;
    end else begin
      clock_output_pin <= (state_reg == COPS_ST_HIGH);
    end
  end

  // ==========================================================================
  // Other resets and power-down
  // ==========================================================================
  // Both arrive from outside the clock domain, so each passes two flops first.
  // They are only passed on to other logic and never reach the postscaler.
  logic [1:0] sys_reset_sync_reg;
  logic [1:0] power_down_sync_reg;
  logic       link_reset_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_sync_reg <= 2'h0;
    end else begin
      sys_reset_sync_reg <= {sys_reset_sync_reg[0], sys_reset_req};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_down_sync_reg <= 2'h0;
    end else begin
      power_down_sync_reg <= {power_down_sync_reg[0], power_down};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_reset_reg <= 1'b0;
    end else begin
      link_reset_reg <= sys_reset_sync_reg[1] & ~power_down_sync_reg[1];
    end
  end

  assign link_domain_reset = link_reset_reg;

endmodule

// >>> cops_props.sv
// Port checker for the clock output postscaler.
// Assumes it is bound to cops_top.
`timescale 1ns/1ps
module cops_props
  import cops_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire cops_ctrl_wr_t ctrl_wr,
  input wire logic          power_down,
  input wire logic          clock_output_pin,
  input wire logic [3:0]    clock_output_config,
  input wire logic          change_pending
);
  // Consecutive cycles that a written change has waited for its boundary
  int unsigned pend_run;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_run <= 0;
    end else begin
      pend_run <= change_pending ? pend_run + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CFG_TAKE: assert property (ctrl_wr.wr |=> clock_output_config == $past(ctrl_wr.data[11:8]))
    else $error("config not taken");
  AST_CFG_HOLD: assert property (!ctrl_wr.wr |=> $stable(clock_output_config))
    else $error("config moved");
  AST_POR: assert property ($rose(rst_n) |-> clock_output_config == COPS_CODE_RESET)
    else $error("bad reset config");
  AST_PEND: assert property (ctrl_wr.wr |=> change_pending)
    else $error("pending not set");
  AST_HI_MIN: assert property ($rose(clock_output_pin) |=> clock_output_pin)
    else $error("short high");
  AST_LO_MIN: assert property ($fell(clock_output_pin) |=> !clock_output_pin)
    else $error("short low");
  AST_OFF: assert property ((clock_output_config == 4'h0 && !change_pending)[*2] |-> !clock_output_pin)
    else $error("pin runs while off");
  AST_RUNS: assert property (!change_pending && clock_output_config == 4'h7 |-> ##[1:20] $changed(clock_output_pin))
    else $error("output stalled");
  AST_PEND_END: assert property (pend_run <= 32'h0000_0514)
    else $error("change never applied");
  cover property (ctrl_wr.wr && ctrl_wr.data[11:8] == 4'h0);
  cover property (power_down && $rose(clock_output_pin));
  cover property ($fell(change_pending));
endmodule
bind cops_top cops_props i_cops_props (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
  .power_down(power_down), .clock_output_pin(clock_output_pin),
  .clock_output_config(clock_output_config), .change_pending(change_pending));

// >>> cops_host_model.sv
// Host model clocked from clk_sys, sampling the output pin; measures phase lengths in clk_sys cycles.
// Assumes the pin is sampled on clk_sys.
`timescale 1ns/1ps
module cops_host_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clock_output_pin,
  output int        hi_len,
  output int        lo_len,
  output int        periods
);
  int   run;
  logic last;
  // A period ends when a low phase ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run <= 0;
      last <= 1'b0;
      hi_len <= 0;
      lo_len <= 0;
      periods <= 0;
    end else begin
      last <= clock_output_pin;
      run <= (clock_output_pin == last) ? run + 1 : 1;
      if (clock_output_pin != last && last) hi_len <= run;
      if (clock_output_pin != last && !last) lo_len <= run;
      if (clock_output_pin != last && !last) periods <= periods + 1;
    end
  end
endmodule

// >>> cops_top_bench.sv
// Self-checking bench for the clock output postscaler.
// Assumes a 125 MHz clk_sys and the host model on the pin.
`timescale 1ns/1ps
module cops_top_bench;
  import cops_pkg::*;
  logic clk_sys, rst_n, sys_reset_req, power_down, clock_output_pin, change_pending;
  logic [3:0] clock_output_config, code;
  logic link_domain_reset;
  cops_ctrl_wr_t ctrl_wr;
  int hi_len, lo_len, periods, miscompares, compares, n, p_off;
  int div_tab[16] = '{0, 4, 5, 8, 10, 16, 20, 25, 32, 40, 50, 64, 100, 200, 400, 1000};
  cops_top i_cops_top (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .sys_reset_req(sys_reset_req),
    .power_down(power_down), .clock_output_pin(clock_output_pin), .clock_output_config(clock_output_config),
    .change_pending(change_pending), .link_domain_reset(link_domain_reset));
  cops_host_model i_cops_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .clock_output_pin(clock_output_pin),
    .hi_len(hi_len), .lo_len(lo_len), .periods(periods));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [10:0] exp, logic [10:0] got, logic [10:0] tol);
    compares++;
    if (((got + tol) >= exp && got <= exp + tol) !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_per(int k);
    int p0;
    p0 = periods;
    for (int i = 0; i < 5000 && periods < p0 + k; i++) @(negedge clk_sys);
    if (periods < p0 + k) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wr_cfg(logic [3:0] c);
    @(negedge clk_sys);
    ctrl_wr.data = {4'($urandom), c, 8'($urandom)};
    ctrl_wr.wr = 1'b1;
    sys_reset_req = 1'($urandom);
    power_down = 1'($urandom);
    @(negedge clk_sys);
    ctrl_wr.wr = 1'b0;
    check("config", 11'(c), 11'(clock_output_config), 0);
    check("pending", 1, 11'(change_pending), 0);
  endtask
  initial begin
    ctrl_wr = '0;
    sys_reset_req = 1'b0;
    power_down = 1'b0;
    rst_n = 1'b0;
    void'($urandom(32'h182176dc));
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    check("reset config", 11'h7, 11'(clock_output_config), 0);
    wait_per(3);
    check("reset high", 16, 11'(hi_len), 2);
    check("reset low", 15, 11'(lo_len), 2);
    for (int k = 0; k < 18; k++) begin
      code = (k < 16) ? 4'(k) : 4'($urandom);
      n = div_tab[code];
      wr_cfg(4'($urandom));
      wr_cfg(code);
      if (n == 0) begin
        for (int i = 0; i < 2000 && change_pending; i++) @(negedge clk_sys);
        if (change_pending) begin
          miscompares++;
          results();
        end
        p_off = periods;
        repeat (40) @(negedge clk_sys);
        check("off pin", 0, 11'(clock_output_pin), 0);
        check("off periods", 11'(p_off), 11'(periods), 0);
      end else begin
        wait_per(3);
        check("high", 11'((n + 1) / 2 * 5 / 4), 11'(hi_len), 2);
        check("low", 11'(n / 2 * 5 / 4), 11'(lo_len), 2);
      end
      check("link reset", 11'(sys_reset_req & ~power_down), 11'(link_domain_reset), 0);
      $display("test code %0d done", code);
    end
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    check("second reset config", 11'h7, 11'(clock_output_config), 0);
    wait_per(3);
    check("second reset high", 16, 11'(hi_len), 2);
    check("second reset low", 15, 11'(lo_len), 2);
    $display("test second reset done");
    results();
  end
endmodule
